// ==== bf_pkg.sv ====
`default_nettype none
package bf_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PHASE_THR = 8'h04;
   localparam logic [7:0] OFS_RES_THR = 8'h08;
   localparam logic [7:0] OFS_RETRIP_DLY = 8'h0C;
   localparam logic [7:0] OFS_BF_DLY = 8'h10;
   localparam logic [7:0] OFS_SIG_SEL = 8'h14;
   localparam logic [7:0] OFS_OUT_SEL = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam logic [7:0] OFS_TICK_DIV = 8'h20;
   // control fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_RES_LSB = 4;
   localparam int CTRL_RETRIP_EN_BIT = 8;
   // mode bits: bit0 current, bit1 signals, bit2 outputs, bit3 and-combine
   localparam logic [3:0] MODE_RESET = 4'h1;
   localparam logic [1:0] RES_RESET = 2'h0;
   localparam logic RETRIP_EN_RESET = 1'b1;
   // thresholds in thousandths of nominal current
   localparam logic [15:0] PHASE_THR_RESET = 16'h00C8;
   localparam logic [15:0] RES_THR_RESET = 16'h04B0;
   localparam logic [15:0] PHASE_STEP = 16'h000A;
   // release ratio 97/100
   localparam int REL_NUM = 97;
   localparam int REL_DEN = 100;
   // delays in 5 ms steps
   localparam int STEP_MS = 5;
   localparam logic [18:0] RETRIP_DLY_RESET = 19'h0_0014;
   localparam logic [18:0] BF_DLY_RESET = 19'h0_0028;
   localparam int CLK_MHZ = 200;
   localparam int TICK_CYCLES = STEP_MS * 1000 * CLK_MHZ;
   localparam int BLOCK_LEAD_MS = 5;

   typedef enum logic [2:0] {COND_NORMAL, COND_START, COND_RETRIP, COND_BF, COND_BLOCKED}
      cond_e;

   typedef struct packed {
      logic [15:0] phase_a;
      logic [15:0] phase_b;
      logic [15:0] phase_c;
      logic [15:0] res_one;
      logic [15:0] res_two;
      logic [15:0] res_calc;
   } meas_s;
endpackage : bf_pkg
`default_nettype wire

// ==== bf_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module bf_timer #(
   parameter int W = 19
) (
   input wire logic clk_sys_in, // system clock
   input wire logic reset_n_in, // async reset, active low
   input wire logic run_in, // count enable while condition holds
   input wire logic clear_in, // reset count and output
   input wire logic step_in, // one delay step elapsed
   input wire logic [W-1:0] delay_in, // delay in steps
   output logic done_out // delay elapsed, held until clear
);
   logic [W-1:0] count;
   wire reached = (count >= delay_in);
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         count <= '0;
         done_out <= 1'b0;
      end
      else if (clear_in)
      begin
         count <= '0;
         done_out <= 1'b0;
      end
      else if (run_in)
      begin
         if (reached)
            done_out <= 1'b1;
         else if (step_in)
            count <= count + W'(1);
      end
   end
endmodule : bf_timer
`default_nettype wire

// ==== breaker_failure_supervisor.sv ====
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module breaker_failure_supervisor #(
   parameter int TICK = bf_pkg::TICK_CYCLES,
   parameter int NSIG = 16,
   parameter int NOUT = 16
) (
   input wire logic clk_sys_in, // system clock, 200 MHz
   input wire logic reset_n_in, // async reset, active low
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hsel, // ahb select
   input wire logic hready, // ahb bus ready
   output logic [31:0] hrdata, // ahb read data
   output logic hreadyout, // ahb slave ready
   output logic hresp, // ahb response
   input wire bf_pkg::meas_s meas_in, // current magnitudes, thousandths of nominal
   input wire logic [NSIG-1:0] trip_events_in, // protection trip events
   input wire logic [NOUT-1:0] relay_ctrl_in, // output relay controls
   input wire logic block_in, // block from blocking matrix
   output logic start_out, // start
   output logic blocked_out, // blocked
   output logic retrip_out, // retrip to redundant coil
   output logic breaker_failure_output, // trip to upstream breaker
   output logic cycle_out // program cycle strobe
);
   function automatic logic above(input logic [15:0] m, input logic [15:0] thr,
                                  input logic held);
      // picks up above thr, releases below 97 percent of thr
      logic [23:0] lhs;
      logic [23:0] rhs;
      lhs = 24'(m) * 24'(bf_pkg::REL_DEN);
      rhs = 24'(thr) * 24'(bf_pkg::REL_NUM);
      above = held ? (lhs >= rhs) : (m > thr);
   endfunction : above

   logic [3:0] mode;
   logic [1:0] res_src;
   logic retrip_en;
   logic [15:0] phase_thr;
   logic [15:0] res_thr;
   logic [18:0] retrip_dly;
   logic [18:0] bf_dly;
   logic [NSIG-1:0] sig_sel;
   logic [NOUT-1:0] out_sel;
   logic [31:0] tick_cnt;
   logic blk;
   logic ph_held;
   logic res_held;
   logic active;
   logic rt_done;
   logic bf_done;
   bf_pkg::cond_e cond;

   // bus address phase capture
   logic dp_wr;
   logic [7:0] dp_addr;
   wire take = hsel && hready && htrans[1];
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         dp_wr <= 1'b0;
         dp_addr <= 8'h00;
      end
      else
      begin
         dp_wr <= take && hwrite;
         if (take)
            dp_addr <= haddr[7:0];
      end
   end

   // register writes; phase threshold kept a multiple of 0.01
   wire [15:0] ph_wr = hwdata[15:0] - (hwdata[15:0] % bf_pkg::PHASE_STEP);
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         mode <= bf_pkg::MODE_RESET;
         res_src <= bf_pkg::RES_RESET;
         retrip_en <= bf_pkg::RETRIP_EN_RESET;
         phase_thr <= bf_pkg::PHASE_THR_RESET;
         res_thr <= bf_pkg::RES_THR_RESET;
         retrip_dly <= bf_pkg::RETRIP_DLY_RESET;
         bf_dly <= bf_pkg::BF_DLY_RESET;
         sig_sel <= '0;
         out_sel <= '0;
      end
      else if (dp_wr)
      begin
         case (dp_addr)
            bf_pkg::OFS_CTRL:
            begin
               mode <= hwdata[bf_pkg::CTRL_MODE_LSB +: 4];
               res_src <= hwdata[bf_pkg::CTRL_RES_LSB +: 2];
               retrip_en <= hwdata[bf_pkg::CTRL_RETRIP_EN_BIT];
            end
            bf_pkg::OFS_PHASE_THR: phase_thr <= ph_wr;
            bf_pkg::OFS_RES_THR: res_thr <= hwdata[15:0];
            bf_pkg::OFS_RETRIP_DLY: retrip_dly <= hwdata[18:0];
            bf_pkg::OFS_BF_DLY: bf_dly <= hwdata[18:0];
            bf_pkg::OFS_SIG_SEL: sig_sel <= hwdata[NSIG-1:0];
            bf_pkg::OFS_OUT_SEL: out_sel <= hwdata[NOUT-1:0];
            default: ;
         endcase
      end
   end

   // read mux on the live address, so read data stands through the data phase
   wire [31:0] ctrl_rd = {23'h0, retrip_en, 2'h0, res_src, mode};
   wire [31:0] stat_rd = {24'h0, bf_done, rt_done, active, blk, 1'b0, cond};
   logic [31:0] rd_mux;
   always_comb
   begin
      case (haddr[7:0])
         bf_pkg::OFS_CTRL: rd_mux = ctrl_rd;
         bf_pkg::OFS_PHASE_THR: rd_mux = {16'h0, phase_thr};
         bf_pkg::OFS_RES_THR: rd_mux = {16'h0, res_thr};
         bf_pkg::OFS_RETRIP_DLY: rd_mux = {13'h0, retrip_dly};
         bf_pkg::OFS_BF_DLY: rd_mux = {13'h0, bf_dly};
         bf_pkg::OFS_SIG_SEL: rd_mux = 32'(sig_sel);
         bf_pkg::OFS_OUT_SEL: rd_mux = 32'(out_sel);
         bf_pkg::OFS_STATUS: rd_mux = stat_rd;
         bf_pkg::OFS_TICK_DIV: rd_mux = 32'(TICK);
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         hrdata <= 32'h0000_0000;
      else if (take && !hwrite)
         hrdata <= rd_mux;
   end
   // zero wait state, always okay
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // program cycle: one step of 5 ms
   wire tick = (tick_cnt == 32'(TICK - 1));
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         tick_cnt <= 32'h0000_0000;
      else
         tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
   end

   // block sampled once per program cycle
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         blk <= 1'b0;
      else if (tick)
         blk <= block_in;
   end

   // current pick-up with hysteresis
   logic [15:0] res_m;
   always_comb
   begin
      case (res_src)
         2'd1: res_m = meas_in.res_one;
         2'd2: res_m = meas_in.res_two;
         2'd3: res_m = meas_in.res_calc;
         default: res_m = 16'h0000;
      endcase
   end
   wire ph_now = above(meas_in.phase_a, phase_thr, ph_held) ||
                 above(meas_in.phase_b, phase_thr, ph_held) ||
                 above(meas_in.phase_c, phase_thr, ph_held);
   wire res_now = (res_src != 2'd0) && above(res_m, res_thr, res_held);
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         ph_held <= 1'b0;
         res_held <= 1'b0;
      end
      else
      begin
         ph_held <= ph_now;
         res_held <= res_now;
      end
   end

   // pick-up by mode
   wire cur_c = ph_now || res_now;
   wire sig_c = |(trip_events_in & sig_sel);
   wire out_c = |(relay_ctrl_in & out_sel);
   wire use_and = mode[3];
   wire and_pu = (!mode[0] || cur_c) && (!mode[1] || sig_c) && (!mode[2] || out_c);
   wire or_pu = (mode[0] && cur_c) || (mode[1] && sig_c) || (mode[2] && out_c);
   wire pickup = (mode[2:0] != 3'd0) && (use_and ? and_pu : or_pu);

   // start only without block; block clears timers
   wire run = pickup && !blk;
   wire clr = !pickup || blk;
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         active <= 1'b0;
      else
         active <= run;
   end

   // one pick-up drives both timers
   bf_timer #(.W(19)) u_retrip (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .run_in(run && retrip_en),
      .clear_in(clr || !retrip_en),
      .step_in(tick),
      .delay_in(retrip_dly),
      .done_out(rt_done)
   );
   bf_timer #(.W(19)) u_bf (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .run_in(run),
      .clear_in(clr),
      .step_in(tick),
      .delay_in(bf_dly),
      .done_out(bf_done)
   );

   // condition indicator and outputs
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         cond <= bf_pkg::COND_NORMAL;
         start_out <= 1'b0;
         blocked_out <= 1'b0;
         retrip_out <= 1'b0;
         breaker_failure_output <= 1'b0;
         cycle_out <= 1'b0;
      end
      else
      begin
         start_out <= active;
         blocked_out <= pickup && blk;
         retrip_out <= rt_done;
         breaker_failure_output <= bf_done;
         cycle_out <= tick;
         if (bf_done)
            cond <= bf_pkg::COND_BF;
         else if (rt_done)
            cond <= bf_pkg::COND_RETRIP;
         else if (active)
            cond <= bf_pkg::COND_START;
         else if (pickup && blk)
            cond <= bf_pkg::COND_BLOCKED;
         else
            cond <= bf_pkg::COND_NORMAL;
      end
   end

   property p_block_stops;
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      blk |=> ##1 !start_out;
   endproperty
   a_block_stops: assert property (p_block_stops) else $error("start while blocked");

   sequence s_blocked_quiet;
      blocked_out ##1 !start_out;
   endsequence
   property p_blocked_no_out;
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      (pickup && blk) |=> s_blocked_quiet;
   endproperty
   a_blocked_no_out: assert property (p_blocked_no_out) else $error("blocked wrong");

   property p_start_follows;
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      (pickup && !blk) |=> ##1 start_out;
   endproperty
   a_start_follows: assert property (p_start_follows) else $error("no start");

   property p_drop_clears;
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      !pickup |=> ##1 (!retrip_out && !breaker_failure_output);
   endproperty
   a_drop_clears: assert property (p_drop_clears) else $error("output held");

   property p_retrip_off;
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      !retrip_en |=> ##1 !retrip_out;
   endproperty
   a_retrip_off: assert property (p_retrip_off) else $error("retrip disabled");

   property p_block_sample;
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      !tick |=> $stable(blk);
   endproperty
   a_block_sample: assert property (p_block_sample) else $error("block moved");

   property p_bf_needs_start;
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      $rose(breaker_failure_output) |-> $past(active);
   endproperty
   a_bf_needs_start: assert property (p_bf_needs_start) else $error("bf w/o start");

   property p_cond_bf;
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      bf_done |=> (cond == bf_pkg::COND_BF);
   endproperty
   a_cond_bf: assert property (p_cond_bf) else $error("indicator wrong");

   property p_res_off;
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      (res_src == 2'd0) |-> !res_now;
   endproperty
   a_res_off: assert property (p_res_off) else $error("residual off");
endmodule : breaker_failure_supervisor
`default_nettype wire

// ==== breaker_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module breaker_model #(
   parameter int OPEN_CYCLES = 12
) (
   input wire logic clk_in, // clock
   input wire logic reset_n_in, // async reset, active low
   input wire logic retrip_in, // redundant coil drive
   input wire logic trip_in, // upstream breaker drive
   output logic opened_out // contacts parted
);
   int count;
   // contacts part a fixed time after a coil is energised
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         count <= 0;
         opened_out <= 1'b0;
      end
      else if (!(retrip_in || trip_in))
      begin
         count <= 0;
         opened_out <= 1'b0;
      end
      else
      begin
         if (count < OPEN_CYCLES)
            count <= count + 1;
         opened_out <= (count >= OPEN_CYCLES - 1);
      end
   end
endmodule : breaker_model
`default_nettype wire

// ==== tb_breaker_failure_supervisor.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_breaker_failure_supervisor;
   localparam int TK = 10;
   logic clk_sys_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   bf_pkg::meas_s meas = '0;
   logic [15:0] ev = 16'h0000;
   logic [15:0] rl = 16'h0000;
   logic blk = 1'b0;
   logic start, blocked, retrip, bfo, cyc, opened;
   int bad_count = 0;
   int n_checks = 0;
   int cycles = 0;
   int n;
   logic [31:0] q;

   breaker_failure_supervisor #(.TICK(TK)) breaker_failure_supervisor_i (
      .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .meas_in(meas),
      .trip_events_in(ev), .relay_ctrl_in(rl), .block_in(blk), .start_out(start),
      .blocked_out(blocked), .retrip_out(retrip), .breaker_failure_output(bfo),
      .cycle_out(cyc));
   breaker_model #(.OPEN_CYCLES(5)) breaker_model_i (.clk_in(clk_sys_in),
      .reset_n_in(reset_n_in), .retrip_in(retrip), .trip_in(bfo), .opened_out(opened));

   initial
   begin
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results

   always @(posedge clk_sys_in)
   begin
      cycles = cycles + 1;
      if (cycles == 60000)
      begin
         bad_count++;
         results();
      end
   end

   function automatic logic sig(input int s);
      case (s)
         0: return start;
         1: return blocked;
         2: return retrip;
         3: return bfo;
         4: return cyc;
         default: return opened;
      endcase
   endfunction : sig

   task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk32

   task automatic chkb(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask : chkb

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsel <= 1'b1;
      do @(posedge clk_sys_in); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk_sys_in); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0000_0000);
      chk32(nm, e, q);
      chkb("hresp okay", 1'b0, hresp);
   endtask : rdc

   task automatic cond(input logic [2:0] e);
      bus(1'b0, bf_pkg::OFS_STATUS, 32'h0000_0000);
      chk32("condition", {29'h0, e}, {29'h0, q[2:0]});
   endtask : cond

   // idx 0..2 phases a..c, 3..5 residual one, two, calculated
   task automatic apply(input int idx, input logic [15:0] v, input logic [15:0] e,
                        input logic [15:0] r, input logic b);
      bf_pkg::meas_s m;
      m = '0;
      case (idx)
         0: m.phase_a = v;
         1: m.phase_b = v;
         2: m.phase_c = v;
         3: m.res_one = v;
         4: m.res_two = v;
         default: m.res_calc = v;
      endcase
      @(posedge clk_sys_in);
      meas <= m;
      ev <= e;
      rl <= r;
      blk <= b;
   endtask : apply

   task automatic waitc(input int s, input logic v, input int lim, input string nm);
      n = 0;
      while (sig(s) !== v && n < lim)
      begin
         @(posedge clk_sys_in);
         n++;
      end
      chkb(nm, 1'b1, n < lim);
   endtask : waitc

   task automatic stay(input int s, input logic v, input int lim, input string nm);
      logic ok;
      ok = 1'b1;
      repeat (lim)
      begin
         @(posedge clk_sys_in);
         if (sig(s) !== v)
            ok = 1'b0;
      end
      chkb(nm, 1'b1, ok);
   endtask : stay

   initial
   begin
      repeat (10) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      rdc(bf_pkg::OFS_CTRL, 32'h0000_0101, "ctrl");
      rdc(bf_pkg::OFS_PHASE_THR, 32'h0000_00C8, "phase thr");
      rdc(bf_pkg::OFS_RES_THR, 32'h0000_04B0, "res thr");
      rdc(bf_pkg::OFS_RETRIP_DLY, 32'h0000_0014, "retrip dly");
      rdc(bf_pkg::OFS_BF_DLY, 32'h0000_0028, "bf dly");
      rdc(8'h40, 32'h0000_0000, "unmapped");
      bus(1'b1, bf_pkg::OFS_STATUS, 32'h0000_0007);
      rdc(bf_pkg::OFS_STATUS, 32'h0000_0000, "status");
      bus(1'b1, bf_pkg::OFS_PHASE_THR, 32'h0000_00D3);
      rdc(bf_pkg::OFS_PHASE_THR, 32'h0000_00D2, "phase step");
      bus(1'b1, bf_pkg::OFS_PHASE_THR, 32'h0000_00C8);
      bus(1'b1, bf_pkg::OFS_RETRIP_DLY, 32'h0000_0002);
      bus(1'b1, bf_pkg::OFS_BF_DLY, 32'h0000_0008);
      waitc(4, 1'b1, TK + 2, "cycle strobe");
      // current mode, hysteresis hold, coil clears the fault after retrip
      apply(1, 16'h00C9, 16'h0000, 16'h0000, 1'b0);
      waitc(0, 1'b1, 8, "start");
      apply(1, 16'h00C3, 16'h0000, 16'h0000, 1'b0);
      waitc(2, 1'b1, 4 * TK, "retrip");
      chkb("retrip not early", 1'b1, n >= TK);
      chkb("bf not yet", 1'b0, bfo);
      cond(3'h2);
      waitc(5, 1'b1, 20, "breaker open");
      apply(1, 16'h00C1, 16'h0000, 16'h0000, 1'b0);
      waitc(0, 1'b0, 8, "start release");
      waitc(2, 1'b0, 8, "retrip release");
      stay(3, 1'b0, 9 * TK, "bf stays off");
      for (int i = 0; i < 6; i++)
      begin
         if (i >= 3)
            bus(1'b1, bf_pkg::OFS_CTRL, 32'h0000_0101 | 32'(i - 2) << 4);
         apply(i, (i < 3) ? 16'h00C9 : 16'h0514, 16'h0000, 16'h0000, 1'b0);
         waitc(0, 1'b1, 8, "pickup source");
         apply(i, 16'h0000, 16'h0000, 16'h0000, 1'b0);
         waitc(0, 1'b0, 8, "source drop");
      end
      bus(1'b1, bf_pkg::OFS_CTRL, 32'h0000_0101);
      apply(5, 16'h0514, 16'h0000, 16'h0000, 1'b0);
      stay(0, 1'b0, 2 * TK, "residual off");
      // block ahead of pickup, then block during start
      apply(0, 16'h0000, 16'h0000, 16'h0000, 1'b1);
      repeat (TK + 4) @(posedge clk_sys_in);
      apply(0, 16'h00C9, 16'h0000, 16'h0000, 1'b1);
      waitc(1, 1'b1, 8, "blocked");
      stay(3, 1'b0, 9 * TK, "no trip when blocked");
      chkb("no start when blocked", 1'b0, start);
      cond(3'h4);
      apply(0, 16'h0000, 16'h0000, 16'h0000, 1'b0);
      repeat (TK + 4) @(posedge clk_sys_in);
      apply(0, 16'h00C9, 16'h0000, 16'h0000, 1'b0);
      waitc(0, 1'b1, 8, "start before block");
      apply(0, 16'h00C9, 16'h0000, 16'h0000, 1'b1);
      waitc(0, 1'b0, TK + 8, "start cleared by block");
      stay(3, 1'b0, 9 * TK, "no trip after block");
      apply(0, 16'h0000, 16'h0000, 16'h0000, 1'b0);
      repeat (TK + 4) @(posedge clk_sys_in);
      // retrip disabled, breaker-failure trip held through hysteresis
      bus(1'b1, bf_pkg::OFS_CTRL, 32'h0000_0001);
      apply(2, 16'h00C9, 16'h0000, 16'h0000, 1'b0);
      waitc(3, 1'b1, 10 * TK, "bf");
      chkb("bf not early", 1'b1, n >= 7 * TK);
      chkb("retrip suppressed", 1'b0, retrip);
      cond(3'h3);
      apply(2, 16'h00C3, 16'h0000, 16'h0000, 1'b0);
      stay(3, 1'b1, 2 * TK, "bf held");
      apply(2, 16'h0000, 16'h0000, 16'h0000, 1'b0);
      waitc(3, 1'b0, 8, "bf release");
      // current and output contact
      bus(1'b1, bf_pkg::OFS_OUT_SEL, 32'h0000_0004);
      bus(1'b1, bf_pkg::OFS_CTRL, 32'h0000_010D);
      apply(0, 16'h00C9, 16'h0000, 16'h0001, 1'b0);
      stay(2, 1'b0, 4 * TK, "halted");
      apply(0, 16'h00C9, 16'h0000, 16'h0004, 1'b0);
      waitc(2, 1'b1, 4 * TK, "retrip after contact");
      chkb("contact timed", 1'b1, n >= TK);
      apply(0, 16'h00C9, 16'h0000, 16'h0000, 1'b0);
      waitc(2, 1'b0, 8, "contact drop");
      // current or output contact
      bus(1'b1, bf_pkg::OFS_CTRL, 32'h0000_0105);
      apply(0, 16'h0000, 16'h0000, 16'h0004, 1'b0);
      waitc(2, 1'b1, 4 * TK, "retrip on contact");
      apply(0, 16'h00C9, 16'h0000, 16'h0000, 1'b0);
      stay(2, 1'b1, 8, "held by current");
      apply(0, 16'h0000, 16'h0000, 16'h0000, 1'b0);
      waitc(2, 1'b0, 8, "both dropped");
      // signals only
      bus(1'b1, bf_pkg::OFS_SIG_SEL, 32'h0000_0020);
      bus(1'b1, bf_pkg::OFS_CTRL, 32'h0000_0102);
      apply(0, 16'h0000, 16'h0001, 16'h0000, 1'b0);
      stay(0, 1'b0, 2 * TK, "unselected event");
      apply(0, 16'h0000, 16'h0020, 16'h0000, 1'b0);
      waitc(2, 1'b1, 4 * TK, "retrip on event");
      apply(0, 16'h0000, 16'h0000, 16'h0000, 1'b0);
      waitc(2, 1'b0, 8, "event drop");
      results();
   end
endmodule : tb_breaker_failure_supervisor
`default_nettype wire
